// [bench/sceltc_top_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module sceltc_top_chk
    import sceltc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic [31:0] o_hrdata,
    input wire logic o_irq
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    logic take, wr_q, rd_q;
    logic [3:0] ofs_q;
    logic [31:0] mode_q, alarm_q;
    assign take = i_hsel && i_hready && i_htrans == SCELTC_HTRANS_NONSEQ;
    ////////////////////////////////////////////////////////////////////////////
    // shadow built from bus traffic only; restart bit never reads back
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            ofs_q <= 4'h0;
            mode_q <= {16'h0000, SCELTC_DIV_RESET};
            alarm_q <= SCELTC_ALARM_RESET;
        end else begin
            wr_q <= take && i_hwrite;
            rd_q <= take && !i_hwrite;
            if (take) begin
                ofs_q <= i_haddr[3:0];
            end
            if (wr_q && ofs_q == SCELTC_OFS_MODE) begin
                mode_q <= i_hwdata & 32'h0113_FFFF;
            end
            if (wr_q && ofs_q == SCELTC_OFS_ALARM) begin
                alarm_q <= i_hwdata;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    a_read_wait: assert property (take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (take && i_hwrite |=> o_hreadyout)
        else $error("write stalled");
    a_rdata_holds: assert property (o_hreadyout |=> $stable(o_hrdata))
        else $error("read data moved outside a read");
    a_mode_back: assert property (rd_q && ofs_q == SCELTC_OFS_MODE |=> o_hrdata == mode_q)
        else $error("mode readback wrong");
    a_alarm_back: assert property (rd_q && ofs_q == SCELTC_OFS_ALARM |=> o_hrdata == alarm_q)
        else $error("alarm readback wrong");
    a_status_zeros: assert property (rd_q && ofs_q == SCELTC_OFS_STATUS |=> o_hrdata[31:2] == 30'h0)
        else $error("status reserved bits set");
    a_resp_okay: assert property (o_hresp == SCELTC_HRESP_OKAY)
        else $error("bus response not okay");
    a_irq_masked: assert property (mode_q[17:16] == 2'h0 |-> !o_irq)
        else $error("irq with both enables off");
    a_irq_holds: assert property (take && !i_hwrite && i_haddr[3:0] == SCELTC_OFS_STATUS && o_irq && !wr_q
        |=> o_irq [*2])
        else $error("irq dropped too soon after status read");
    cover property (take && !i_hwrite && i_haddr[3:0] == SCELTC_OFS_STATUS && o_irq);
    cover property (rd_q && ofs_q == SCELTC_OFS_ALARM);
    cover property ($rose(o_irq));
endmodule
bind sceltc_top sceltc_top_chk u_sceltc_top_chk (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata), .o_irq(o_irq));
`default_nettype wire

// [bench/test_sceltc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module test_sceltc_top
    import sceltc_pkg::*;
;
    logic clk = 0, rstn = 0, slow = 0, tick = 0, hsel = 0, hwrite = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    wire logic hrdy, hresp, irq;
    wire logic [31:0] hrdata;
    int num_errors = 0, checked = 0;
    always #50 clk = ~clk;
    sceltc_top u_sceltc_top (.i_core_clk(clk), .i_resetn(rstn), .i_slow_clock(slow), .i_second_tick(tick),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata), .o_irq(irq));
    ////////////////////////////////////////////////////////////////////////////
    task automatic ahb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {28'h0, a};
        hwrite <= w;
        htrans <= SCELTC_HTRANS_NONSEQ;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_irq(input logic exp);
        // irq is a level: look mid-cycle, hand back on a rising edge
        @(negedge clk);
        checked++;
        if (irq !== exp) begin
            num_errors++;
            $display("Error at %0t: irq %b, expected %b", $time, irq, exp);
        end
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    // slow clock and tick only move here, so every count below is exact
    task automatic pulse(input int n, input logic t);
        repeat (n) begin
            if (t) tick <= 1'b1;
            else slow <= 1'b1;
            repeat (2) @(posedge clk);
            tick <= 1'b0;
            slow <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d, errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        complete_run;
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(SCELTC_OFS_MODE, 32'h0000_8000);
        rd(SCELTC_OFS_ALARM, 32'hFFFF_FFFF);
        rd(SCELTC_OFS_VALUE, 32'h0);
        rd(SCELTC_OFS_STATUS, 32'h0);
        wr(SCELTC_OFS_MODE, 32'h0004_0003);
        pulse(6, 1'b0);
        rd(SCELTC_OFS_VALUE, 32'h2);
        rd(SCELTC_OFS_VALUE, 32'h2);
        chk_irq(1'b0);
        wr(SCELTC_OFS_MODE, 32'h0002_0003);
        chk_irq(1'b1);
        rd(SCELTC_OFS_STATUS, 32'h2);
        chk_irq(1'b1);
        pulse(1, 1'b0);
        chk_irq(1'b1);
        pulse(1, 1'b0);
        chk_irq(1'b0);
        rd(SCELTC_OFS_STATUS, 32'h0);
        // divider sits mid-period here; a restart must drop that progress
        wr(SCELTC_OFS_MODE, 32'h0004_0003);
        rd(SCELTC_OFS_VALUE, 32'h0);
        pulse(2, 1'b0);
        rd(SCELTC_OFS_VALUE, 32'h0);
        pulse(1, 1'b0);
        rd(SCELTC_OFS_VALUE, 32'h1);
        wr(SCELTC_OFS_ALARM, 32'h3);
        wr(SCELTC_OFS_MODE, 32'h0005_0003);
        pulse(11, 1'b0);
        chk_irq(1'b0);
        pulse(1, 1'b0);
        chk_irq(1'b1);
        rd(SCELTC_OFS_STATUS, 32'h3);
        wr(SCELTC_OFS_MODE, 32'h0104_0003);
        pulse(3, 1'b0);
        rd(SCELTC_OFS_VALUE, 32'h0);
        pulse(2, 1'b1);
        rd(SCELTC_OFS_VALUE, 32'h2);
        rd(SCELTC_OFS_STATUS, 32'h2);
        pulse(2, 1'b0);
        // disabled with the tick selected: neither source may move anything
        wr(SCELTC_OFS_MODE, 32'h0114_0003);
        pulse(6, 1'b0);
        pulse(2, 1'b1);
        rd(SCELTC_OFS_VALUE, 32'h0);
        rd(SCELTC_OFS_STATUS, 32'h0);
        complete_run;
    end
endmodule
`default_nettype wire

// [inc/sceltc_pkg.sv]
package sceltc_pkg;
    // register map, byte addresses on a 32-bit bus
    localparam logic [3:0] SCELTC_OFS_MODE = 4'h0;
    localparam logic [3:0] SCELTC_OFS_ALARM = 4'h4;
    localparam logic [3:0] SCELTC_OFS_VALUE = 4'h8;
    localparam logic [3:0] SCELTC_OFS_STATUS = 4'hC;
    localparam int SCELTC_ADDR_BITS = 4;

    // timer_mode field positions
    localparam int SCELTC_MODE_DIV_LSB = 0;
    localparam int SCELTC_MODE_DIV_MSB = 15;
    localparam int SCELTC_MODE_ALM_IEN = 16;
    localparam int SCELTC_MODE_INC_IEN = 17;
    localparam int SCELTC_MODE_RESTART = 18;
    localparam int SCELTC_MODE_DISABLE = 20;
    localparam int SCELTC_MODE_SEC_SEL = 24;

    // timer_status field positions
    localparam int SCELTC_STAT_ALARM = 0;
    localparam int SCELTC_STAT_INC = 1;

    // reset values
    localparam logic [15:0] SCELTC_DIV_RESET = 16'h8000;
    localparam logic [31:0] SCELTC_ALARM_RESET = 32'hFFFF_FFFF;
    localparam logic [31:0] SCELTC_COUNT_RESET = 32'h0000_0000;

    // widths
    localparam int SCELTC_DIV_W = 16;
    localparam int SCELTC_CNT_W = 32;

    // slow-clock edges between a status read and the flag clear
    localparam logic [1:0] SCELTC_CLEAR_LAG = 2'h2;

    // ahb-lite encodings
    localparam logic [1:0] SCELTC_HTRANS_NONSEQ = 2'h2;
    localparam logic SCELTC_HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        SCELTC_BUS_IDLE,
        SCELTC_BUS_WRITE,
        SCELTC_BUS_READ_WAIT,
        SCELTC_BUS_READ_DATA
    } sceltc_bus_t;
endpackage

// [verilog/sceltc_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
module sceltc_prescaler
    import sceltc_pkg::*;
#(
    parameter int DIV_W = SCELTC_DIV_W
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_step,
    input wire logic i_restart,
    input wire logic [DIV_W-1:0] i_divisor,
    output logic o_rollover
);
    logic [DIV_W-1:0] div_count_reg;
    logic [DIV_W-1:0] terminal;

    // a divisor of zero wraps the terminal to all ones, a full 2^DIV_W period
    assign terminal = i_divisor - {{(DIV_W-1){1'b0}}, 1'b1}; // R2
    assign o_rollover = i_step && !i_restart && (div_count_reg == terminal); // R1

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div_count_reg <= '0;
        end else if (i_restart) begin
            div_count_reg <= '0; // R12
        end else if (o_rollover) begin
            div_count_reg <= '0;
        end else if (i_step) begin
            div_count_reg <= div_count_reg + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire

// [verilog/sceltc_top.sv]
// Functional notes
// R1: 32-bit up-counter advances once per period of a 16-bit slow-clock divider.
// R2: divider period is divisor slow clocks, or 65536 when divisor is zero.
// R3: counter wraps from all ones to zero and keeps counting.
// R4: mode bit 24 picks divider roll-over or external 1 Hz tick as count source.
// R5: with the 1 Hz tick selected the divider still runs and flags increments.
// R6: every divider roll-over sets increment_flag, status bit 1.
// R7: alarm_flag, status bit 0, sets when counter equals alarm_match_value plus one.
// R8: alarm register resets to all ones.
// R9: reading the status register clears both flags.
// R10: that clear lands two slow-clock cycles after the read.
// R11: interrupt is alarm_flag with bit 16, or increment_flag with bit 17.
// R12: writing 1 to bit 18 restarts the divider and clears the counter.
// R13: bit 20 set stops divider and counter.
// R14: value register reads the present counter.
// R15: software reads the value twice and keeps it once two reads agree.
// R16: software clears increment_irq_en before changing the divisor.
// R17: software clears alarm_irq_en before changing the alarm value.
// R18: divisor of 3 or more recommended; 1 or 2 may lose events.
// R19: mode register resets with divisor 0x8000.
// R20: slow clock and 1 Hz tick are brought into the core clock safely; the code has no synchronizer and takes both as already synchronous.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sceltc_top
    import sceltc_pkg::*;
#(
    parameter int DIV_W = SCELTC_DIV_W,
    parameter int CNT_W = SCELTC_CNT_W
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_slow_clock,
    input wire logic i_second_tick,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    output logic o_irq
);
    ////////////////////////////////////////////////////////////////////////
    // register and state declarations
    sceltc_bus_t bus_state_reg;
    logic [SCELTC_ADDR_BITS-1:0] bus_addr_reg;
    logic [31:0] hrdata_reg;
    logic [DIV_W-1:0] prescale_divisor_reg;
    logic alarm_irq_en_reg;
    logic increment_irq_en_reg;
    logic timer_disable_reg;
    logic calibrated_second_select_reg;
    logic [CNT_W-1:0] alarm_match_value_reg;
    logic [CNT_W-1:0] current_count_reg;
    logic [CNT_W-1:0] current_count_next;
    logic alarm_flag_reg;
    logic increment_flag_reg;
    logic slow_prev_reg;
    logic tick_prev_reg;
    logic clear_pending_reg;
    logic [1:0] clear_lag_reg;

    logic addr_accept;
    logic write_commit;
    logic read_capture;
    logic mode_write;
    logic alarm_write;
    logic restart_pulse;
    logic status_read;
    logic slow_edge;
    logic tick_edge;
    logic div_step;
    logic div_rollover;
    logic count_advance;
    logic alarm_hit;
    logic flag_clear;
    logic [31:0] read_mux;

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: writes take no wait state, reads take one so that
    // a read right behind a write already sees the written value
    assign addr_accept = i_hsel && i_hready && (i_htrans == SCELTC_HTRANS_NONSEQ);
    assign o_hreadyout = (bus_state_reg != SCELTC_BUS_READ_WAIT);
    assign o_hresp = SCELTC_HRESP_OKAY;
    assign o_hrdata = hrdata_reg;
    assign write_commit = (bus_state_reg == SCELTC_BUS_WRITE);
    assign read_capture = (bus_state_reg == SCELTC_BUS_READ_WAIT);

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            bus_state_reg <= SCELTC_BUS_IDLE;
        end else begin
            case (bus_state_reg)
                SCELTC_BUS_READ_WAIT: begin
                    bus_state_reg <= SCELTC_BUS_READ_DATA;
                end
                SCELTC_BUS_IDLE,
                SCELTC_BUS_WRITE,
                SCELTC_BUS_READ_DATA: begin
                    if (addr_accept) begin
                        bus_state_reg <= i_hwrite ? SCELTC_BUS_WRITE : SCELTC_BUS_READ_WAIT;
                    end else begin
                        bus_state_reg <= SCELTC_BUS_IDLE;
                    end
                end
                default: begin
                    bus_state_reg <= SCELTC_BUS_IDLE;
                end
            endcase
        end
    end

    // the address is latched only at a taken address phase; during the read
    // wait hready is low, so no later phase can overwrite it
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            bus_addr_reg <= '0;
        end else if (addr_accept && (bus_state_reg != SCELTC_BUS_READ_WAIT)) begin
            bus_addr_reg <= i_haddr[SCELTC_ADDR_BITS-1:0];
        end
    end

    // low address bits only; hsel already decodes the block's window
    assign mode_write = write_commit && (bus_addr_reg == SCELTC_OFS_MODE);
    assign alarm_write = write_commit && (bus_addr_reg == SCELTC_OFS_ALARM);
    assign restart_pulse = mode_write && i_hwdata[SCELTC_MODE_RESTART]; // R12
    assign status_read = read_capture && (bus_addr_reg == SCELTC_OFS_STATUS);

    always_comb begin
        // reserved bits and unmapped offsets read as zero
        read_mux = 32'h0000_0000;
        case (bus_addr_reg)
            SCELTC_OFS_MODE: begin
                read_mux[SCELTC_MODE_DIV_MSB:SCELTC_MODE_DIV_LSB] = prescale_divisor_reg;
                read_mux[SCELTC_MODE_ALM_IEN] = alarm_irq_en_reg;
                read_mux[SCELTC_MODE_INC_IEN] = increment_irq_en_reg;
                read_mux[SCELTC_MODE_DISABLE] = timer_disable_reg;
                read_mux[SCELTC_MODE_SEC_SEL] = calibrated_second_select_reg;
            end
            SCELTC_OFS_ALARM: begin
                read_mux = alarm_match_value_reg;
            end
            SCELTC_OFS_VALUE: begin
                read_mux = current_count_reg; // R14
            end
            SCELTC_OFS_STATUS: begin
                read_mux[SCELTC_STAT_ALARM] = alarm_flag_reg;
                read_mux[SCELTC_STAT_INC] = increment_flag_reg;
            end
            default: begin
                read_mux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (read_capture) begin
            hrdata_reg <= read_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers
    // the restart bit is a strobe and is never stored, so it reads back as 0;
    // a divisor change with the increment interrupt on may give one odd period
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            prescale_divisor_reg <= SCELTC_DIV_RESET; // R19
            alarm_irq_en_reg <= 1'b0;
            increment_irq_en_reg <= 1'b0;
            timer_disable_reg <= 1'b0;
            calibrated_second_select_reg <= 1'b0;
        end else if (mode_write) begin
            prescale_divisor_reg <= i_hwdata[SCELTC_MODE_DIV_MSB:SCELTC_MODE_DIV_LSB];
            alarm_irq_en_reg <= i_hwdata[SCELTC_MODE_ALM_IEN];
            increment_irq_en_reg <= i_hwdata[SCELTC_MODE_INC_IEN];
            timer_disable_reg <= i_hwdata[SCELTC_MODE_DISABLE];
            calibrated_second_select_reg <= i_hwdata[SCELTC_MODE_SEC_SEL];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            alarm_match_value_reg <= SCELTC_ALARM_RESET; // R8
        end else if (alarm_write) begin
            // a new alarm value applies from the next counter step
            alarm_match_value_reg <= i_hwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slow clock and 1 Hz tick arrive synchronous to the core clock, so a
    // single previous-value flop per input is enough to find rising edges
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            slow_prev_reg <= 1'b0;
            tick_prev_reg <= 1'b0;
        end else begin
            slow_prev_reg <= i_slow_clock; // R20
            tick_prev_reg <= i_second_tick; // R20
        end
    end

    assign slow_edge = i_slow_clock && !slow_prev_reg; // R20
    assign tick_edge = i_second_tick && !tick_prev_reg; // R20

    ////////////////////////////////////////////////////////////////////////
    // divider and counter
    // disable gates every step, so only a restart write moves divider and counter while the timer is off
    assign div_step = slow_edge && !timer_disable_reg; // R13

    sceltc_prescaler #(
        .DIV_W(DIV_W)
    ) u_prescaler (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_step(div_step),
        .i_restart(restart_pulse),
        .i_divisor(prescale_divisor_reg),
        .o_rollover(div_rollover)
    );

    // the divider keeps rolling with the tick selected; it only loses the counter
    always_comb begin
        if (calibrated_second_select_reg) begin
            count_advance = tick_edge && !timer_disable_reg; // R4 R5 R13
        end else begin
            count_advance = div_rollover; // R4 R1
        end
    end

    assign current_count_next = current_count_reg + {{(CNT_W-1){1'b0}}, 1'b1}; // R3

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            current_count_reg <= SCELTC_COUNT_RESET;
        end else if (restart_pulse) begin
            // restart beats a same-cycle advance so the first period after it is whole
            current_count_reg <= SCELTC_COUNT_RESET; // R12
        end else if (count_advance) begin
            current_count_reg <= current_count_next; // R1 R3
        end
    end

    // compare on the step that lands the counter on the alarm value plus one
    assign alarm_hit = count_advance && !restart_pulse &&
        (current_count_next == (alarm_match_value_reg + {{(CNT_W-1){1'b0}}, 1'b1})); // R7

    ////////////////////////////////////////////////////////////////////////
    // status flags; the read-clear waits for two slow-clock edges, so a
    // divisor of 1 or 2 can see a new event swallowed by a late clear
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            clear_pending_reg <= 1'b0;
            clear_lag_reg <= 2'h0;
        end else if (status_read) begin
            // a second status read inside the lag starts the count again
            clear_pending_reg <= 1'b1; // R9
            clear_lag_reg <= 2'h0;
        end else if (flag_clear) begin
            clear_pending_reg <= 1'b0;
            clear_lag_reg <= 2'h0;
        end else if (clear_pending_reg && slow_edge) begin
            clear_lag_reg <= clear_lag_reg + 2'h1; // R10
        end
    end

    assign flag_clear = clear_pending_reg && slow_edge &&
        (clear_lag_reg == (SCELTC_CLEAR_LAG - 2'h1)); // R10

    // a set in the clearing cycle wins over the clear
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            increment_flag_reg <= 1'b0;
        end else if (div_rollover) begin
            increment_flag_reg <= 1'b1; // R6 R5
        end else if (flag_clear) begin
            increment_flag_reg <= 1'b0; // R9
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            alarm_flag_reg <= 1'b0;
        end else if (alarm_hit) begin
            alarm_flag_reg <= 1'b1; // R7
        end else if (flag_clear) begin
            alarm_flag_reg <= 1'b0; // R9
        end
    end

    // stays high through the clear lag after a status read
    assign o_irq = (alarm_flag_reg && alarm_irq_en_reg) ||
        (increment_flag_reg && increment_irq_en_reg); // R11 R10
endmodule
`default_nettype wire
